// ==== ssru_map.vh ====
// Purpose: Register indices, command codes and reset values of the status unit
// Assumes: Included by the design, the checker and the bench files
// Notes: Register indices select a register on the command port, not a byte address
`ifndef SSRU_MAP_VH
`define SSRU_MAP_VH

// Command codes on the request port
`define SSRU_CMD_READ 4'h0
`define SSRU_CMD_WRITE 4'h1
`define SSRU_CMD_ERR_NEXT 4'h2
`define SSRU_CMD_ERR_CODE 4'h3
`define SSRU_CMD_ERR_ALL 4'h4
`define SSRU_CMD_ERR_COUNT 4'h5
`define SSRU_CMD_ERR_CODE_ALL 4'h6

// Register indices: operation register parts
`define SSRU_REG_OPER_COND 4'h0
`define SSRU_REG_OPER_RISE 4'h1
`define SSRU_REG_OPER_FALL 4'h2
`define SSRU_REG_OPER_EVT 4'h3
`define SSRU_REG_OPER_MASK 4'h4
// Register indices: questionable register parts
`define SSRU_REG_QUES_COND 4'h5
`define SSRU_REG_QUES_RISE 4'h6
`define SSRU_REG_QUES_FALL 4'h7
`define SSRU_REG_QUES_EVT 4'h8
`define SSRU_REG_QUES_MASK 4'h9
// Register indices: standard event pair and status byte pair
`define SSRU_REG_ESR_EVT 4'ha
`define SSRU_REG_ESR_MASK 4'hb
`define SSRU_REG_STB 4'hc
`define SSRU_REG_SRE 4'hd

// Status byte bit positions
`define SSRU_STB_ERRQ 2
`define SSRU_STB_QUES 3
`define SSRU_STB_MAV 4
`define SSRU_STB_ESB 5
`define SSRU_STB_MSS 6
`define SSRU_STB_OPER 7

// Operation register bit fed by calibration activity
`define SSRU_OPER_CAL_BIT 0

// Reset values (15 stored bits in the register parts, 8 in ESE and SRE; bit 15 is never stored)
`define SSRU_RISE_RST 15'h7fff
`define SSRU_FALL_RST 15'h0000
`define SSRU_MASK_RST 15'h0000
`define SSRU_ESE_RST 8'h00
`define SSRU_SRE_RST 8'h00

// Answer for an empty error queue
`define SSRU_NO_ERROR 32'h0000_0000

`endif

// ==== ssru_top.v ====
// Purpose: Status reporting unit with two 16-bit status registers, standard
//          event pair, status byte with service request, and an error queue
// Assumes: All inputs come from logic on I_CLK_SYS; host commands are decoded
//          upstream from the remote link into the request port below
// Notes: Bit 15 of every 16-bit part is never stored and always reads zero
`timescale 1ns/1ps
`include "ssru_map.vh"
`default_nettype none

// One SCPI-style register: condition, two edge filters, event, mask
module ssru_status_reg (
  // Clock, reset, enable
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  // Condition source
  input wire [14:0] i_cond,
  // Controller access
  input wire [14:0] i_wdata,
  input wire i_we_rise,
  input wire i_we_fall,
  input wire i_we_mask,
  input wire i_evt_rd,
  // Part contents and sum
  output wire [14:0] o_rise,
  output wire [14:0] o_fall,
  output wire [14:0] o_evt,
  output wire [14:0] o_mask,
  output wire o_sum
);
  reg [14:0] rise_reg, fall_reg, evt_reg, mask_reg, cond_prev_reg;
  wire [14:0] rise_hit;
  wire [14:0] fall_hit;
  wire [14:0] evt_next;

  // Per-bit edge filters; bit positions line up across all parts
  assign rise_hit = i_cond & ~cond_prev_reg & rise_reg;
  assign fall_hit = ~i_cond & cond_prev_reg & fall_reg;
  // New edges are OR'd after the clear so they are never lost
  assign evt_next = (i_evt_rd ? 15'h0000 : evt_reg) | rise_hit | fall_hit;
  assign o_sum = |(evt_reg & mask_reg);
  assign o_rise = rise_reg;
  assign o_fall = fall_reg;
  assign o_evt = evt_reg;
  assign o_mask = mask_reg;

  // Filter and mask parts change only on writes; reads never touch them
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rise_reg <= `SSRU_RISE_RST;
      fall_reg <= `SSRU_FALL_RST;
      mask_reg <= `SSRU_MASK_RST;
      evt_reg <= 15'h0000;
      cond_prev_reg <= 15'h0000;
    end else if (i_ce) begin
      if (i_we_rise) begin
        rise_reg <= i_wdata;
      end
      if (i_we_fall) begin
        fall_reg <= i_wdata;
      end
      if (i_we_mask) begin
        mask_reg <= i_wdata;
      end
      evt_reg <= evt_next;
      cond_prev_reg <= i_cond;
    end
  end
endmodule

module ssru_top #(
  parameter QUEUE_DEPTH = 8,
  parameter QUEUE_AW = 3
) (
  // Clock, reset, enable
  input wire I_CLK_SYS,
  input wire I_RESETN,
  input wire I_CE,
  // Command port from the remote link decoder
  input wire I_REQ_VALID,
  input wire [3:0] I_REQ_CMD,
  input wire [3:0] I_REQ_REG,
  input wire [15:0] I_REQ_WDATA,
  output wire O_REQ_READY,
  output wire O_RSP_VALID,
  output wire [31:0] O_RSP_DATA,
  output wire O_RSP_LAST,
  // Status sources
  input wire [14:0] I_OPER_COND,
  input wire I_CAL_BUSY,
  input wire [14:0] I_QUES_COND,
  input wire [7:0] I_ESR_SET,
  input wire I_MSG_AVAIL,
  // Error queue feed
  input wire I_ERR_PUSH,
  input wire [15:0] I_ERR_CODE,
  input wire [15:0] I_ERR_MSG,
  // Status byte and service request
  output wire [7:0] O_STB,
  output wire O_SRQ
);
  // Depth cut to the count width on purpose; the count never exceeds it
  localparam [QUEUE_AW:0] DEPTH_CNT = QUEUE_DEPTH[QUEUE_AW:0];

  reg [15:0] code_mem [0:QUEUE_DEPTH-1];
  reg [15:0] msg_mem [0:QUEUE_DEPTH-1];
  reg [QUEUE_AW-1:0] rd_ptr_reg;
  reg [QUEUE_AW-1:0] wr_ptr_reg;
  reg [QUEUE_AW:0] cnt_reg;
  reg [QUEUE_AW-1:0] all_ptr_reg;
  reg [QUEUE_AW:0] all_left_reg;
  reg all_code_reg;
  reg [7:0] esr_reg;
  reg [7:0] ese_reg;
  reg [7:0] sre_reg;
  reg [7:0] stb_reg;
  reg srq_reg;
  reg rsp_valid_reg;
  reg rsp_last_reg;
  reg [31:0] rsp_data_reg;
  reg [31:0] rsp_data_next;
  reg rsp_valid_next;
  reg rsp_last_next;
  reg [15:0] reg_rdata;

  wire take;
  wire is_read;
  wire is_write;
  wire queue_empty;
  wire pop;
  wire push_ok;
  wire start_all;
  wire [14:0] oper_cond;
  wire [14:0] oper_rise, oper_fall, oper_evt, oper_mask;
  wire oper_sum;
  wire [14:0] ques_rise, ques_fall, ques_evt, ques_mask;
  wire ques_sum;
  wire esb;
  wire [7:0] stb_raw;
  wire [7:0] sre_eff;
  wire mss;
  wire [7:0] esr_next;

  // Requests are refused while a read-all stream is still running
  assign O_REQ_READY = (all_left_reg == {(QUEUE_AW+1){1'b0}});
  assign take = I_CE & I_REQ_VALID & O_REQ_READY;
  assign is_read = take & (I_REQ_CMD == `SSRU_CMD_READ);
  assign is_write = take & (I_REQ_CMD == `SSRU_CMD_WRITE);
  assign queue_empty = (cnt_reg == {(QUEUE_AW+1){1'b0}});
  // Next and code requests both consume the head; empty queue stays as is
  assign pop = take & ~queue_empty & ((I_REQ_CMD == `SSRU_CMD_ERR_NEXT) |
    (I_REQ_CMD == `SSRU_CMD_ERR_CODE));
  // A full queue drops the new entry unless a pop frees a slot this cycle
  assign push_ok = I_CE & I_ERR_PUSH & ((cnt_reg != DEPTH_CNT) | pop);
  assign start_all = take & ((I_REQ_CMD == `SSRU_CMD_ERR_ALL) |
    (I_REQ_CMD == `SSRU_CMD_ERR_CODE_ALL));

  // Calibration activity drives operation bit 0
  assign oper_cond = {I_OPER_COND[14:1], I_CAL_BUSY};

  // Operation status register
  ssru_status_reg u_oper (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_ce(I_CE),
    .i_cond(oper_cond),
    .i_wdata(I_REQ_WDATA[14:0]),
    .i_we_rise(is_write & (I_REQ_REG == `SSRU_REG_OPER_RISE)),
    .i_we_fall(is_write & (I_REQ_REG == `SSRU_REG_OPER_FALL)),
    .i_we_mask(is_write & (I_REQ_REG == `SSRU_REG_OPER_MASK)),
    .i_evt_rd(is_read & (I_REQ_REG == `SSRU_REG_OPER_EVT)),
    .o_rise(oper_rise),
    .o_fall(oper_fall),
    .o_evt(oper_evt),
    .o_mask(oper_mask),
    .o_sum(oper_sum)
  );

  // Questionable status register
  ssru_status_reg u_ques (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_ce(I_CE),
    .i_cond(I_QUES_COND),
    .i_wdata(I_REQ_WDATA[14:0]),
    .i_we_rise(is_write & (I_REQ_REG == `SSRU_REG_QUES_RISE)),
    .i_we_fall(is_write & (I_REQ_REG == `SSRU_REG_QUES_FALL)),
    .i_we_mask(is_write & (I_REQ_REG == `SSRU_REG_QUES_MASK)),
    .i_evt_rd(is_read & (I_REQ_REG == `SSRU_REG_QUES_EVT)),
    .o_rise(ques_rise),
    .o_fall(ques_fall),
    .o_evt(ques_evt),
    .o_mask(ques_mask),
    .o_sum(ques_sum)
  );

  // Standard event pair: clear on read, fresh events win over the clear
  assign esr_next = ((is_read & (I_REQ_REG == `SSRU_REG_ESR_EVT)) ? 8'h00 : esr_reg) |
    I_ESR_SET;
  assign esb = |(esr_reg & ese_reg);

  // Status byte: sums from below become its condition bits
  assign stb_raw = {oper_sum, 1'b0, esb, I_MSG_AVAIL, ques_sum, ~queue_empty,
    2'b00};
  assign sre_eff = sre_reg & 8'hbf;
  assign mss = |(stb_raw & sre_eff);
  assign O_STB = stb_reg;
  assign O_SRQ = srq_reg;
  assign O_RSP_VALID = rsp_valid_reg;
  assign O_RSP_DATA = rsp_data_reg;
  assign O_RSP_LAST = rsp_last_reg;

  // Register read mux; condition parts reflect live state and bit 15 is zero
  always @* begin
    case (I_REQ_REG)
      `SSRU_REG_OPER_COND: reg_rdata = {1'b0, oper_cond};
      `SSRU_REG_OPER_RISE: reg_rdata = {1'b0, oper_rise};
      `SSRU_REG_OPER_FALL: reg_rdata = {1'b0, oper_fall};
      `SSRU_REG_OPER_EVT: reg_rdata = {1'b0, oper_evt};
      `SSRU_REG_OPER_MASK: reg_rdata = {1'b0, oper_mask};
      `SSRU_REG_QUES_COND: reg_rdata = {1'b0, I_QUES_COND};
      `SSRU_REG_QUES_RISE: reg_rdata = {1'b0, ques_rise};
      `SSRU_REG_QUES_FALL: reg_rdata = {1'b0, ques_fall};
      `SSRU_REG_QUES_EVT: reg_rdata = {1'b0, ques_evt};
      `SSRU_REG_QUES_MASK: reg_rdata = {1'b0, ques_mask};
      `SSRU_REG_ESR_EVT: reg_rdata = {8'h00, esr_reg};
      `SSRU_REG_ESR_MASK: reg_rdata = {8'h00, ese_reg};
      `SSRU_REG_STB: reg_rdata = {8'h00, stb_reg};
      `SSRU_REG_SRE: reg_rdata = {8'h00, sre_reg};
      default: reg_rdata = 16'h0000;
    endcase
  end

  // Answer selection; one answer per taken request except writes, plus stream beats
  always @* begin
    rsp_valid_next = 1'b0;
    rsp_last_next = 1'b0;
    rsp_data_next = rsp_data_reg;
    if (!O_REQ_READY) begin
      // Stream beat from the snapshot pointer
      rsp_valid_next = 1'b1;
      rsp_last_next = (all_left_reg == {{QUEUE_AW{1'b0}}, 1'b1});
      rsp_data_next = all_code_reg ? {16'h0000, code_mem[all_ptr_reg]} :
        {msg_mem[all_ptr_reg], code_mem[all_ptr_reg]};
    end else if (take) begin
      rsp_valid_next = ~is_write;
      rsp_last_next = ~is_write;
      case (I_REQ_CMD)
        `SSRU_CMD_READ: rsp_data_next = {16'h0000, reg_rdata};
        `SSRU_CMD_ERR_NEXT: rsp_data_next = queue_empty ? `SSRU_NO_ERROR :
          {msg_mem[rd_ptr_reg], code_mem[rd_ptr_reg]};
        `SSRU_CMD_ERR_CODE: rsp_data_next = queue_empty ? `SSRU_NO_ERROR :
          {16'h0000, code_mem[rd_ptr_reg]};
        `SSRU_CMD_ERR_COUNT: rsp_data_next = {{(31-QUEUE_AW){1'b0}}, cnt_reg};
        `SSRU_CMD_ERR_ALL, `SSRU_CMD_ERR_CODE_ALL: begin
          rsp_last_next = (cnt_reg <= {{QUEUE_AW{1'b0}}, 1'b1});
          if (queue_empty) begin
            rsp_data_next = `SSRU_NO_ERROR;
          end else if (I_REQ_CMD == `SSRU_CMD_ERR_CODE_ALL) begin
            rsp_data_next = {16'h0000, code_mem[rd_ptr_reg]};
          end else begin
            rsp_data_next = {msg_mem[rd_ptr_reg], code_mem[rd_ptr_reg]};
          end
        end
        default: rsp_data_next = 32'h0000_0000;
      endcase
    end
  end

  // Error queue storage; entries are only written at the tail
  always @(posedge I_CLK_SYS) begin
    if (push_ok) begin
      code_mem[wr_ptr_reg] <= I_ERR_CODE;
      msg_mem[wr_ptr_reg] <= I_ERR_MSG;
    end
  end

  // Queue pointers, count and read-all stream; stream reads a snapshot count
  always @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rd_ptr_reg <= {QUEUE_AW{1'b0}};
      wr_ptr_reg <= {QUEUE_AW{1'b0}};
      cnt_reg <= {(QUEUE_AW+1){1'b0}};
      all_ptr_reg <= {QUEUE_AW{1'b0}};
      all_left_reg <= {(QUEUE_AW+1){1'b0}};
      all_code_reg <= 1'b0;
    end else if (I_CE) begin
      if (push_ok) begin
        wr_ptr_reg <= wr_ptr_reg + {{(QUEUE_AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(QUEUE_AW-1){1'b0}}, 1'b1};
      end
      if (push_ok & ~pop) begin
        cnt_reg <= cnt_reg + {{QUEUE_AW{1'b0}}, 1'b1};
      end else if (pop & ~push_ok) begin
        cnt_reg <= cnt_reg - {{QUEUE_AW{1'b0}}, 1'b1};
      end
      if (start_all & (cnt_reg > {{QUEUE_AW{1'b0}}, 1'b1})) begin
        all_ptr_reg <= rd_ptr_reg + {{(QUEUE_AW-1){1'b0}}, 1'b1};
        all_left_reg <= cnt_reg - {{QUEUE_AW{1'b0}}, 1'b1};
        all_code_reg <= (I_REQ_CMD == `SSRU_CMD_ERR_CODE_ALL);
      end else if (!O_REQ_READY) begin
        all_ptr_reg <= all_ptr_reg + {{(QUEUE_AW-1){1'b0}}, 1'b1};
        all_left_reg <= all_left_reg - {{QUEUE_AW{1'b0}}, 1'b1};
      end
    end
  end

  // Standard event pair, status byte, service request and answer registers
  always @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      esr_reg <= 8'h00;
      ese_reg <= `SSRU_ESE_RST;
      sre_reg <= `SSRU_SRE_RST;
      stb_reg <= 8'h00;
      srq_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_last_reg <= 1'b0;
      rsp_data_reg <= 32'h0000_0000;
    end else if (I_CE) begin
      esr_reg <= esr_next;
      if (is_write & (I_REQ_REG == `SSRU_REG_ESR_MASK)) begin
        ese_reg <= I_REQ_WDATA[7:0];
      end
      if (is_write & (I_REQ_REG == `SSRU_REG_SRE)) begin
        sre_reg <= I_REQ_WDATA[7:0] & 8'hbf;
      end
      stb_reg <= stb_raw | {1'b0, mss, 6'h00};
      // Pulse only on a 0-to-1 change of an enabled bit
      srq_reg <= |(stb_raw & ~stb_reg & sre_eff);
      rsp_valid_reg <= rsp_valid_next;
      rsp_last_reg <= rsp_last_next;
      rsp_data_reg <= rsp_data_next;
    end
  end
endmodule
`default_nettype wire

// ==== ssru_props.sv ====
// Purpose: Port-level checker for the status reporting unit
// Assumes: One clock domain; clock enable gates every state change
// Notes: Bound to ssru_top from the bench top file
`timescale 1ns/1ps
`include "ssru_map.vh"
`default_nettype none

module ssru_props #(
  parameter QUEUE_DEPTH = 8,
  parameter QUEUE_AW = 3
) (
  // Clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_CE,
  // Command port
  input wire logic I_REQ_VALID,
  input wire logic [3:0] I_REQ_CMD,
  input wire logic O_REQ_READY,
  input wire logic O_RSP_VALID,
  input wire logic [31:0] O_RSP_DATA,
  input wire logic O_RSP_LAST,
  // Status byte and its sources
  input wire logic I_MSG_AVAIL,
  input wire logic I_ERR_PUSH,
  input wire logic [7:0] O_STB,
  input wire logic O_SRQ
);
  wire take;

  // A request is accepted only when enabled, valid and ready meet
  assign take = I_CE & I_REQ_VALID & O_REQ_READY;

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);

  chk_query_answered: assert property (
    take && I_REQ_CMD != `SSRU_CMD_WRITE |=> O_RSP_VALID) else $error("query not answered");
  chk_write_silent: assert property (
    take && I_REQ_CMD == `SSRU_CMD_WRITE |=> !O_RSP_VALID) else $error("write answered");
  chk_read_bit15: assert property (
    take && I_REQ_CMD == `SSRU_CMD_READ |=> O_RSP_DATA[31:15] == 17'h00000)
    else $error("register read has high bits set");
  chk_single_beat: assert property (
    take && I_REQ_CMD inside {`SSRU_CMD_ERR_NEXT, `SSRU_CMD_ERR_CODE, `SSRU_CMD_ERR_COUNT}
    |=> O_RSP_LAST) else $error("single answer not marked last");
  chk_code_only: assert property (
    take && I_REQ_CMD == `SSRU_CMD_ERR_CODE |=> O_RSP_DATA[31:16] == 16'h0000)
    else $error("code answer carries message");
  chk_stream_busy: assert property (
    O_RSP_VALID && !O_RSP_LAST |-> !O_REQ_READY) else $error("ready during stream");
  chk_answer_ends: assert property (
    I_CE && O_RSP_VALID && O_RSP_LAST && !take |=> !O_RSP_VALID)
    else $error("answer beat repeated");
  chk_mav_track: assert property (
    I_CE |=> O_STB[`SSRU_STB_MAV] == $past(I_MSG_AVAIL)) else $error("message flag wrong");
  chk_queue_flag: assert property (
    I_CE && I_ERR_PUSH |-> ##2 O_STB[`SSRU_STB_ERRQ]) else $error("queue flag not set");
  chk_mss_cause: assert property (
    O_STB[`SSRU_STB_MSS] |-> O_STB[7] || O_STB[5:2] != 4'h0) else $error("summary without cause");
  chk_srq_summary: assert property (
    O_SRQ |-> O_STB[`SSRU_STB_MSS]) else $error("service request without summary");
endmodule

`default_nettype wire

// ==== ssru_host.sv ====
// Purpose: Remote controller model driving the command port
// Assumes: Requests change just after a rising edge of i_clk
// Notes: Released request lines are inverted so stale fields are never reused
`timescale 1ns/1ps
`include "ssru_map.vh"
`default_nettype none

module ssru_host (
  // Clock
  input wire logic i_clk,
  // Request lines
  input wire logic i_ready,
  output logic o_valid,
  output logic [3:0] o_cmd,
  output logic [3:0] o_reg,
  output logic [15:0] o_wdata,
  // Answer lines
  input wire logic i_rsp_valid,
  input wire logic [31:0] i_rsp_data,
  input wire logic i_rsp_last
);
  logic [31:0] rsp_q[$];
  int waits;

  // Quiet request lines from time zero
  initial begin
    o_valid = 1'b0;
    o_cmd = 4'h0;
    o_reg = 4'h0;
    o_wdata = 16'h0000;
  end

  // Release the port
  task automatic idle();
    o_valid = 1'b0;
    o_cmd = ~o_cmd;
    o_reg = ~o_reg;
    o_wdata = ~o_wdata;
  endtask

  // Hold a request until taken, then gather beats up to the last one
  task automatic req(input logic [3:0] cmd, input logic [3:0] idx, input logic [15:0] wd);
    rsp_q.delete();
    o_valid = 1'b1;
    o_cmd = cmd;
    o_reg = idx;
    o_wdata = wd;
    waits = 0;
    while (i_ready !== 1'b1 && waits < 50) begin
      @(posedge i_clk);
      #1;
      waits++;
    end
    @(posedge i_clk);
    #1;
    waits = (cmd == `SSRU_CMD_WRITE) ? 20 : 0;
    while (waits < 20) begin
      if (i_rsp_valid === 1'b1) rsp_q.push_back(i_rsp_data);
      if (i_rsp_valid === 1'b1 && i_rsp_last === 1'b1) break;
      @(posedge i_clk);
      #1;
      waits++;
    end
  endtask
endmodule

`default_nettype wire

// ==== ssru_tb.sv ====
// Purpose: Self-checking bench for the status reporting unit
// Assumes: Clock enable stays high except for one low stretch in the standard event test; a short error queue reaches full quickly
// Notes: One fixed seed makes every random run repeat
`timescale 1ns/1ps
`include "ssru_map.vh"
`default_nettype none

module testbench;
  localparam int DEPTH = 4;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic cal_busy = 1'b0;
  logic msg_avail = 1'b0;
  logic err_push = 1'b0;
  logic [14:0] oper_cond = 15'h0000;
  logic [14:0] ques_cond = 15'h0000;
  logic [7:0] esr_set = 8'h00;
  logic [15:0] err_code = 16'h0000;
  logic [15:0] err_msg = 16'h0000;
  logic req_valid, req_ready, rsp_valid, rsp_last, srq;
  logic [3:0] req_cmd, req_reg;
  logic [15:0] req_wdata;
  logic [31:0] rsp_data;
  logic [7:0] stb;
  int miscompares = 0;
  int checks_done = 0;

  // System clock
  always #25 clk_sys = ~clk_sys;

  ssru_top #(.QUEUE_DEPTH(DEPTH), .QUEUE_AW(2)) u_ssru_top (
    .I_CLK_SYS(clk_sys), .I_RESETN(resetn), .I_CE(ce), .I_REQ_VALID(req_valid),
    .I_REQ_CMD(req_cmd), .I_REQ_REG(req_reg), .I_REQ_WDATA(req_wdata),
    .O_REQ_READY(req_ready), .O_RSP_VALID(rsp_valid), .O_RSP_DATA(rsp_data),
    .O_RSP_LAST(rsp_last), .I_OPER_COND(oper_cond), .I_CAL_BUSY(cal_busy),
    .I_QUES_COND(ques_cond), .I_ESR_SET(esr_set), .I_MSG_AVAIL(msg_avail),
    .I_ERR_PUSH(err_push), .I_ERR_CODE(err_code), .I_ERR_MSG(err_msg),
    .O_STB(stb), .O_SRQ(srq)
  );

  ssru_host u_ssru_host (
    .i_clk(clk_sys), .i_ready(req_ready), .o_valid(req_valid), .o_cmd(req_cmd),
    .o_reg(req_reg), .o_wdata(req_wdata), .i_rsp_valid(rsp_valid),
    .i_rsp_data(rsp_data), .i_rsp_last(rsp_last)
  );

  // Event bits expected from one condition change through both filters
  function automatic logic [15:0] edge_evt(input logic [14:0] a, b, r, f);
    return {1'b0, (~a & b & r) | (a & ~b & f)};
  endfunction

  // Read-back of a register index after writing w; read-only places keep zero
  function automatic logic [15:0] wr_val(input int idx, input logic [15:0] w);
    case (idx)
      1, 2, 4, 6, 7, 9: return {1'b0, w[14:0]};
      11: return {8'h00, w[7:0]};
      13: return {8'h00, w[7:0] & 8'hbf};
      default: return 16'h0000;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic gap(input int n);
    u_ssru_host.idle();
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic ask(input logic [3:0] cmd, input logic [3:0] idx, input logic [31:0] exp,
                     input string what);
    u_ssru_host.req(cmd, idx, 16'h0000);
    check(u_ssru_host.rsp_q[0], exp, what);
  endtask

  // Input bit 0 of the operation word gets the opposite value, as it must be ignored
  task automatic cond_set(input int base, input logic [14:0] v);
    if (base == 0) begin
      oper_cond = {v[14:1], ~v[0]};
      cal_busy = v[0];
    end else begin
      ques_cond = v;
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence; requests run back to back unless a gap is asked for
  initial begin
    logic [14:0] a, b, r, f, m;
    logic [15:0] w, ev;
    logic [7:0] e;
    logic [31:0] ent[$];
    int base, sb;
    void'($urandom(54352));
    repeat (16) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      w = (i == 1 || i == 6) ? {1'b0, `SSRU_RISE_RST} : 16'h0000;
      ask(`SSRU_CMD_READ, 4'(i), {16'h0000, w}, "reset value");
    end
    $display("test reset values done");
    for (int i = 0; i < 16; i++) begin
      w = 16'($urandom());
      u_ssru_host.req(`SSRU_CMD_WRITE, 4'(i), w);
      ask(`SSRU_CMD_READ, 4'(i), {16'h0000, wr_val(i, w)}, "write back");
    end
    $display("test register access done");
    for (int k = 0; k < 6; k++) begin
      base = (k % 2) * 5;
      {a, b, r, f, m} = {15'($urandom()), 15'($urandom()), 15'($urandom()),
                         15'($urandom()), 15'($urandom())};
      cond_set(base, a);
      gap(4);
      u_ssru_host.req(`SSRU_CMD_WRITE, 4'(base + 1), {1'b0, r});
      u_ssru_host.req(`SSRU_CMD_WRITE, 4'(base + 2), {1'b0, f});
      u_ssru_host.req(`SSRU_CMD_WRITE, 4'(base + 4), {1'b0, m});
      u_ssru_host.req(`SSRU_CMD_WRITE, `SSRU_REG_SRE, 16'h0088);
      u_ssru_host.req(`SSRU_CMD_READ, 4'(base + 3), 16'h0000);
      cond_set(base, b);
      gap(4);
      ev = edge_evt(a, b, r, f);
      sb = (base == 0) ? `SSRU_STB_OPER : `SSRU_STB_QUES;
      check(stb[sb], |(ev[14:0] & m), "summary bit");
      check(stb[`SSRU_STB_MSS], |(ev[14:0] & m), "master summary");
      ask(`SSRU_CMD_READ, 4'(base), {17'h00000, b}, "condition");
      ask(`SSRU_CMD_READ, 4'(base + 3), {16'h0000, ev}, "event");
      ask(`SSRU_CMD_READ, 4'(base + 3), 32'h0000_0000, "event cleared");
    end
    $display("test edge filters done");
    u_ssru_host.req(`SSRU_CMD_WRITE, `SSRU_REG_ESR_MASK, 16'h00ff);
    // Bit 6 written here must be dropped; only the event summary may request service
    u_ssru_host.req(`SSRU_CMD_WRITE, `SSRU_REG_SRE, 16'h0060);
    e = 8'($urandom()) | 8'h01;
    esr_set = e;
    msg_avail = 1'b1;
    gap(1);
    esr_set = 8'h00;
    gap(1);
    check(srq, 1'b1, "service request");
    gap(1);
    check(srq, 1'b0, "service request ends");
    gap(2);
    check(stb[`SSRU_STB_MSS], 1'b1, "summary from events");
    check(stb[`SSRU_STB_ESB], 1'b1, "event summary");
    check(stb[`SSRU_STB_MAV], 1'b1, "message waiting");
    ask(`SSRU_CMD_READ, `SSRU_REG_ESR_EVT, {24'h000000, e}, "standard events");
    ask(`SSRU_CMD_READ, `SSRU_REG_ESR_EVT, 32'h0000_0000, "standard cleared");
    msg_avail = 1'b0;
    // A set pulse while the enable is low must leave no trace
    ce = 1'b0;
    esr_set = 8'h01;
    gap(3);
    esr_set = 8'h00;
    ce = 1'b1;
    ask(`SSRU_CMD_READ, `SSRU_REG_ESR_EVT, 32'h0000_0000, "frozen set ignored");
    $display("test standard events done");
    gap(1);
    for (int i = 0; i < DEPTH + 1; i++) begin
      err_code = 16'($urandom());
      err_msg = 16'($urandom());
      err_push = 1'b1;
      if (i < DEPTH) ent.push_back({err_msg, err_code});
      @(posedge clk_sys);
      #1;
    end
    err_push = 1'b0;
    gap(2);
    check(stb[`SSRU_STB_ERRQ], 1'b1, "queue flag");
    ask(`SSRU_CMD_ERR_COUNT, 4'h0, 32'(DEPTH), "full count");
    u_ssru_host.req(`SSRU_CMD_ERR_ALL, 4'h0, 16'h0000);
    check(32'(u_ssru_host.rsp_q.size()), 32'(DEPTH), "stream length");
    foreach (ent[j]) check(u_ssru_host.rsp_q[j], ent[j], "stream entry");
    u_ssru_host.req(`SSRU_CMD_ERR_CODE_ALL, 4'h0, 16'h0000);
    foreach (ent[j]) check(u_ssru_host.rsp_q[j], {16'h0000, ent[j][15:0]}, "code");
    ask(`SSRU_CMD_ERR_COUNT, 4'h0, 32'(DEPTH), "count kept");
    ask(`SSRU_CMD_ERR_NEXT, 4'h0, ent[0], "oldest entry");
    ask(`SSRU_CMD_ERR_CODE, 4'h0, {16'h0000, ent[1][15:0]}, "next code");
    ask(`SSRU_CMD_ERR_COUNT, 4'h0, 32'(DEPTH - 2), "count after removal");
    ask(`SSRU_CMD_ERR_NEXT, 4'h0, ent[2], "third entry");
    ask(`SSRU_CMD_ERR_NEXT, 4'h0, ent[3], "fourth entry");
    ask(`SSRU_CMD_ERR_NEXT, 4'h0, `SSRU_NO_ERROR, "empty next");
    ask(`SSRU_CMD_ERR_CODE, 4'h0, `SSRU_NO_ERROR, "empty code");
    ask(`SSRU_CMD_ERR_COUNT, 4'h0, 32'h0000_0000, "empty count");
    gap(3);
    check(stb[`SSRU_STB_ERRQ], 1'b0, "queue flag clear");
    $display("test error queue done");
    close_out();
  end

  // Watchdog far above the roughly 200 cycles the tests take
  initial begin
    #(4000 * 50);
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    close_out();
  end
endmodule

bind ssru_top ssru_props #(.QUEUE_DEPTH(QUEUE_DEPTH), .QUEUE_AW(QUEUE_AW)) u_ssru_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_CE(I_CE), .I_REQ_VALID(I_REQ_VALID),
  .I_REQ_CMD(I_REQ_CMD), .O_REQ_READY(O_REQ_READY), .O_RSP_VALID(O_RSP_VALID),
  .O_RSP_DATA(O_RSP_DATA), .O_RSP_LAST(O_RSP_LAST), .I_MSG_AVAIL(I_MSG_AVAIL),
  .I_ERR_PUSH(I_ERR_PUSH), .O_STB(O_STB), .O_SRQ(O_SRQ)
);

`default_nettype wire
